// File: rscc_defines.svh
// Constants for the reset, strap and clock configuration block
`ifndef RSCC_DEFINES_SVH
`define RSCC_DEFINES_SVH
`define RSCC_CLK_MHZ 250
`define RSCC_REG_SYSCLK_OFS 16'h0004
`define RSCC_SYSCLK_RST 32'h0000_0000
`define RSCC_SYSCLK_SEL_LSB 0
`define RSCC_SYSCLK_SEL_W 3
`define RSCC_SYSCLK_SEL_MAX 3'h4
`define RSCC_RSTOUT_MS 200
`define RSCC_RSTOUT_CYC (`RSCC_RSTOUT_MS * 1000 * `RSCC_CLK_MHZ)
`define RSCC_WIDTH_RSVD 2'h0
`define RSCC_WIDTH_8 2'h1
`define RSCC_WIDTH_16 2'h2
`define RSCC_WIDTH_32 2'h3
`endif

// File: rscc_pkg.sv
// Types for the reset, strap and clock configuration block
package rscc_pkg;
	typedef enum logic [1:0] {
		RSCC_BUS_RSVD,
		RSCC_BUS_8,
		RSCC_BUS_16,
		RSCC_BUS_32
	} rscc_bus_width_t;
	typedef enum logic {
		RSCC_RST_RUN,
		RSCC_RST_HOLD
	} rscc_rst_state_t;
endpackage

// File: rscc_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module rscc_sync3 #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	// Each bit moves once its two settled stages agree, so busy neighbours cannot block it
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q_o <= '0;
		end else begin
			q_o <= ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & q_o);
		end
	end
endmodule
`default_nettype wire

// File: rscc_top.sv
// Reset sequencing, strap capture and system clock configuration
`include "rscc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module rscc_top
	import rscc_pkg::*;
#(
	parameter int RSTOUT_CYC = `RSCC_RSTOUT_CYC,
	parameter int SDRAM_W = 32
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Board reset pin
	input wire logic chip_reset_n_i,
	// Watchdog expiry from timer block
	input wire logic wdog_expire_i,
	// Strap pins, shared with normal functions
	input wire logic [1:0] boot_bank_width_strap_i,
	input wire logic reset_out_polarity_strap_i,
	input wire logic cpu_clock_source_strap_i,
	input wire logic bridge_mode_strap_i,
	input wire logic factory_test_strap_i,
	// Register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	// Reset outputs
	output logic system_reset_out_o,
	output logic core_reset_o,
	output logic pins_oe_o,
	// Captured configuration
	output rscc_bus_width_t boot_bank_width_o,
	output logic boot_width_valid_o,
	output logic cpu_clk_bypass_o,
	output logic bridge_host_mode_o,
	output logic factory_test_o,
	// PLL control and clock select
	output logic [2:0] pll_sel_o,
	output logic sdram_clock_out_en_o,
	// SDRAM read capture
	input wire logic sdram_clock_return_i,
	input wire logic [SDRAM_W-1:0] sdram_rdata_i,
	output logic [SDRAM_W-1:0] sdram_rdata_o
);
	localparam int CNT_W = $clog2(RSTOUT_CYC + 1);

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [6:0] pins_s;
	rscc_sync3 #(.W(7)) u_sync (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.d_i({~chip_reset_n_i, boot_bank_width_strap_i, reset_out_polarity_strap_i,
			cpu_clock_source_strap_i, bridge_mode_strap_i, factory_test_strap_i}),
		.q_o(pins_s)
	);
	logic ext_rst_s;
	assign ext_rst_s = pins_s[6];

	////////////////////////////////////////////////////////////////////////////
	// Reset sequencing
	rscc_rst_state_t st_r;
	logic [CNT_W-1:0] hold_cnt_r;
	logic rst_active;
	// A watchdog event or the pin keeps the hold counter reloaded
	assign rst_active = ext_rst_s | wdog_expire_i;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_r <= RSCC_RST_HOLD;
			hold_cnt_r <= '0;
		end else begin
			case (st_r)
				RSCC_RST_RUN: begin
					if (rst_active) begin
						st_r <= RSCC_RST_HOLD;
						hold_cnt_r <= '0;
					end
				end
				RSCC_RST_HOLD: begin
					if (rst_active) begin
						hold_cnt_r <= '0;
					end else if (hold_cnt_r >= CNT_W'(RSTOUT_CYC - 1)) begin
						st_r <= RSCC_RST_RUN;
					end else begin
						hold_cnt_r <= hold_cnt_r + 1'b1;
					end
				end
				default: st_r <= RSCC_RST_HOLD;
			endcase
		end
	end
	logic in_reset;
	assign in_reset = (st_r == RSCC_RST_HOLD);
	assign core_reset_o = in_reset;
	assign pins_oe_o = ~in_reset;

	////////////////////////////////////////////////////////////////////////////
	// Strap capture; straps are only sampled while held in reset
	logic [1:0] width_r;
	logic pol_r;
	logic bypass_r;
	logic host_r;
	logic test_r;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			width_r <= `RSCC_WIDTH_32;
			pol_r <= 1'b0;
			bypass_r <= 1'b0;
			host_r <= 1'b0;
			test_r <= 1'b0;
		end else if (in_reset) begin
			width_r <= pins_s[5:4];
			pol_r <= pins_s[3];
			bypass_r <= pins_s[2];
			host_r <= pins_s[1];
			test_r <= pins_s[0];
		end
	end
	assign boot_bank_width_o = rscc_bus_width_t'(width_r);
	assign boot_width_valid_o = (width_r != `RSCC_WIDTH_RSVD);
	assign cpu_clk_bypass_o = bypass_r;
	assign bridge_host_mode_o = host_r;
	assign factory_test_o = test_r;

	// Reset output in registered form; polarity set by the strap
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			system_reset_out_o <= 1'b1;
		end else begin
			system_reset_out_o <= in_reset ^ pol_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// System clock and bus control register
	logic [31:0] sysclk_r;
	logic sel_hit;
	assign sel_hit = (reg_addr_i == `RSCC_REG_SYSCLK_OFS);
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sysclk_r <= `RSCC_SYSCLK_RST;
		end else if (in_reset) begin
			sysclk_r <= `RSCC_SYSCLK_RST;
		end else if (reg_wr_i && sel_hit) begin
			sysclk_r <= reg_wdata_i;
		end
	end
	// Out-of-range codes clamp to the fastest step rather than overclock
	logic [2:0] sel_raw;
	assign sel_raw = sysclk_r[`RSCC_SYSCLK_SEL_LSB +: `RSCC_SYSCLK_SEL_W];
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pll_sel_o <= 3'h0;
		end else begin
			pll_sel_o <= (sel_raw > `RSCC_SYSCLK_SEL_MAX) ? `RSCC_SYSCLK_SEL_MAX : sel_raw;
		end
	end
	assign sdram_clock_out_en_o = ~in_reset;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			reg_rdata_o <= sel_hit ? {sysclk_r[31:8], 3'h0, in_reset, pol_r, pll_sel_o} : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// SDRAM read capture on the returned clock; no reset, data path only
	always_ff @(posedge sdram_clock_return_i) begin
		sdram_rdata_o <= sdram_rdata_i;
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	a_strap_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!in_reset && !$past(in_reset) |-> $stable(width_r) && $stable(pol_r))
		else $error("strap value changed outside reset");
	a_strap_take: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		in_reset |=> bypass_r == $past(pins_s[2]) && host_r == $past(pins_s[1]))
		else $error("strap not captured in reset");
	a_rst_pol: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		##1 system_reset_out_o == ($past(in_reset) ^ $past(pol_r)))
		else $error("reset output polarity wrong");
	a_wdog_rst: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		wdog_expire_i |=> in_reset)
		else $error("watchdog did not reset");
	a_ext_rst: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		ext_rst_s |=> in_reset && hold_cnt_r == '0)
		else $error("reset pin not followed");
	a_hold_min: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		$fell(in_reset) |-> $past(hold_cnt_r) == CNT_W'(RSTOUT_CYC - 1))
		else $error("reset released early");
	a_pins_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		in_reset |-> !pins_oe_o && !sdram_clock_out_en_o)
		else $error("pins driven in reset");
	a_clk_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		reg_wr_i && sel_hit && !in_reset |=> sysclk_r == $past(reg_wdata_i))
		else $error("clock register not written");
	a_clk_range: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		pll_sel_o <= `RSCC_SYSCLK_SEL_MAX)
		else $error("pll select out of range");
	a_width_code: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		boot_width_valid_o == (boot_bank_width_o != RSCC_BUS_RSVD))
		else $error("width validity wrong");
	c_wdog: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!in_reset ##1 wdog_expire_i ##1 in_reset);
	c_release: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) $fell(in_reset));
	c_write: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) reg_wr_i && sel_hit && !in_reset);
	c_low_pol: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) pol_r && !in_reset);
endmodule
`default_nettype wire

// File: rscc_board.sv
// Board model: reset circuit and strap resistors
`timescale 1ns/1ps
`default_nettype none
module rscc_board (
	// Clock, request and device state
	input wire logic ref_clk_i,
	input wire logic go_i,
	input wire logic core_reset_i,
	input wire logic [4:0] cfg_i,
	// Reset pin and straps {width, polarity, clock source, bridge}
	output logic chip_reset_n_o,
	output logic [4:0] strap_o,
	output logic factory_test_strap_o
);
	int cnt = 0;
	initial chip_reset_n_o = 1'b1;
	initial strap_o = 5'h00;
	// Held well past the minimum so the input filter cannot trim it
	always @(posedge ref_clk_i) begin
		cnt <= go_i ? 300 : (cnt > 0 ? cnt - 1 : 0);
		chip_reset_n_o <= !(go_i || cnt > 1);
		// Shared pins carry traffic once the device runs
		strap_o <= (!chip_reset_n_o || core_reset_i || go_i) ? cfg_i : ~strap_o;
	end
	assign factory_test_strap_o = 1'b0;
endmodule
`default_nettype wire

// File: rscc_tb.sv
// Self-checking bench for the reset, strap and clock block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import rscc_pkg::*;
	localparam int RC = 20;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic wd = 1'b0;
	logic go = 1'b0;
	logic sdclk = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] ad = 16'h0000;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] sdd = 32'h0000_0000;
	logic [31:0] seed = 32'h0000_002f;
	logic [4:0] cfg = 5'h00;
	logic [4:0] st;
	logic [31:0] rdat, sdq;
	logic [2:0] pll;
	logic rn, ft_s, sro, cro, oe, bwv, byp, host, ft, sden;
	rscc_bus_width_t bwo;
	int miscompares = 0;
	int checked = 0;
	int mreg = 0;
	int n;
	always #2 ref_clk_i = ~ref_clk_i;
	// Returned SDRAM clock, unrelated in phase
	always #3.3 sdclk = ~sdclk;
	rscc_board brd (.ref_clk_i(ref_clk_i), .go_i(go), .core_reset_i(cro), .cfg_i(cfg),
		.chip_reset_n_o(rn), .strap_o(st), .factory_test_strap_o(ft_s));
	rscc_top #(.RSTOUT_CYC(RC)) dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.chip_reset_n_i(rn), .wdog_expire_i(wd), .boot_bank_width_strap_i(st[4:3]),
		.reset_out_polarity_strap_i(st[2]), .cpu_clock_source_strap_i(st[1]),
		.bridge_mode_strap_i(st[0]), .factory_test_strap_i(ft_s), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(ad), .reg_wdata_i(wdat), .reg_rdata_o(rdat), .system_reset_out_o(sro),
		.core_reset_o(cro), .pins_oe_o(oe), .boot_bank_width_o(bwo), .boot_width_valid_o(bwv),
		.cpu_clk_bypass_o(byp), .bridge_host_mode_o(host), .factory_test_o(ft), .pll_sel_o(pll),
		.sdram_clock_out_en_o(sden), .sdram_clock_return_i(sdclk), .sdram_rdata_i(sdd),
		.sdram_rdata_o(sdq));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [2:0] clp(input int r);
		return (r[2:0] > 3'h4) ? 3'h4 : r[2:0];
	endfunction
	function automatic logic [31:0] erd();
		return {mreg[31:8], 4'h0, cfg[2], clp(mreg)};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		wr <= w;
		rd <= !w;
		ad <= a;
		wdat <= d;
		@(posedge ref_clk_i);
		wr <= 1'b0;
		rd <= 1'b0;
		@(negedge ref_clk_i);
	endtask
	// Counts settled cycles of held reset; bounded so a stuck reset cannot hang
	task automatic hold_len();
		n = 0;
		while (cro === 1'b1 && n < 600) begin
			@(negedge ref_clk_i);
			n++;
		end
		// Registered reset output trails the core reset by one cycle
		@(negedge ref_clk_i);
	endtask
	task automatic straps();
		chk("width", cfg[4:3], bwo);
		chk("valid", cfg[4:3] != 2'h0, bwv);
		chk("rsto_idle", cfg[2], sro);
		chk("bypass", cfg[1], byp);
		chk("host", cfg[0], host);
		chk("ftest", 0, ft);
	endtask
	task automatic close_out();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			void'(rnd());
			@(posedge ref_clk_i);
			cfg <= {k[1:0], seed[2:0]};
			go <= 1'b1;
			@(posedge ref_clk_i);
			go <= 1'b0;
			repeat (40) @(posedge ref_clk_i);
			@(negedge ref_clk_i);
			chk("oe_rst", 0, {oe, sden});
			chk("rsto_on", !cfg[2], sro);
			if (k == 0)
				acc(1'b1, 16'h0004, 32'hffff_ffff);
			hold_len();
			chk("oe_run", 3, {oe, sden});
			straps();
			if (k == 0)
				acc(1'b0, 16'h0004, 32'h0000_0000);
			if (k == 0)
				chk("sysclk_rst", erd(), rdat);
			for (int j = 0; j < 8; j++) begin
				mreg = rnd();
				mreg[2:0] = j[2:0];
				acc(1'b1, 16'h0004, mreg);
				acc(1'b1, 16'h0008, rnd());
				acc(1'b0, 16'h000c, 32'h0000_0000);
				chk("unmapped", 0, rdat);
				acc(1'b0, 16'h0004, 32'h0000_0000);
				chk("sysclk", erd(), rdat);
				chk("pll", clp(mreg), pll);
			end
			straps();
			@(posedge ref_clk_i);
			wd <= 1'b1;
			@(posedge ref_clk_i);
			wd <= 1'b0;
			repeat (2) @(posedge ref_clk_i);
			@(negedge ref_clk_i);
			chk("wd_rst", {2'b10, !cfg[2]}, {cro, oe, sro});
			hold_len();
			chk("wd_len", 1, n >= RC - 5 && n <= RC + 2);
			straps();
		end
		for (int j = 0; j < 8; j++) begin
			@(negedge sdclk);
			sdd <= rnd();
			@(posedge sdclk);
			#1 chk("sdram", sdd, sdq);
		end
		close_out();
	end
	initial begin
		#100000;
		miscompares++;
		close_out();
	end
endmodule
`default_nettype wire
